// >>> include/slf_regs.svh
`ifndef SLF_REGS_SVH
`define SLF_REGS_SVH

// ***********************************************
// Management register offsets (byte addresses).
// ***********************************************
`define SLF_INDIRECT_ADDRESS_OFS 16'h7200
`define SLF_INDIRECT_DATA_OFS 16'h7206

// ***********************************************
// Indirect SGMII register numbers.
// ***********************************************
`define SLF_PCS_CONTROL_NUM 32'h001f0000
`define SLF_AUTONEG_STATUS_NUM 32'h001f8002

// ***********************************************
// Field positions.
// ***********************************************
`define SLF_CTL_SPEED_LSB 13
`define SLF_CTL_DUPLEX 8
`define SLF_CTL_SPEED_MSB 6
`define SLF_CTL_RESET 15
`define SLF_STS_AN_DONE 0
`define SLF_STS_LINK 1
`define SLF_STS_SPEED_LSB 2
`define SLF_STS_SPEED_MSB 3
`define SLF_STS_DUPLEX 4

// ***********************************************
// Reset values and speed codes.
// ***********************************************
`define SLF_PCS_CONTROL_RST 16'h1140
`define SLF_INDIRECT_ADDRESS_RST 32'h00000000
`define SLF_SPEED_1000 2'h2
`define SLF_SPEED_100 2'h1
`define SLF_SPEED_10 2'h0

`endif

// >>> include/slf_pkg.sv
package slf_pkg;

  // Link conditions seen by the SGMII auto-negotiation receiver.
  typedef struct packed {
    logic an_done;
    logic link_up;
    logic [1:0] speed;
    logic full_duplex;
  } slf_link_s;

  // Settings applied to the port's PCS and gigabit MAC.
  typedef struct packed {
    logic [1:0] speed;
    logic full_duplex;
    logic pcs_reset;
  } slf_mac_cfg_s;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic wide;
    logic [15:0] addr;
    logic [31:0] wdata;
  } slf_req_s;

endpackage : slf_pkg

// >>> design/slf_link_forward.sv
`timescale 1ns/1ps
`include "slf_regs.svh"
module slf_link_forward
  import slf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic phy_mode,
  input wire slf_req_s req,
  output logic ack,
  output logic [31:0] rdata,
  input wire slf_link_s link,
  output slf_mac_cfg_s mac_cfg,
  output logic an_done_evt
);

  // ***********************************************
  // Register storage.
  // ***********************************************
  logic [31:0] indirect_address;
  logic [15:0] pcs_control;
  logic an_done_q;

  // ***********************************************
  // Decoding and status word assembly.
  // ***********************************************
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction : hit

  function automatic logic [1:0] ctl_speed(input logic [15:0] c);
    return {c[`SLF_CTL_SPEED_MSB], c[`SLF_CTL_SPEED_LSB]};
  endfunction : ctl_speed

  logic [15:0] status_word;
  logic [1:0] rep_speed;
  logic addr_wr;
  logic data_wr;
  logic data_rd;
  logic ctl_sel;
  logic sts_sel;

  // In PHY mode this end sets the rate, so the status speed field shows its own setting.
  assign rep_speed = phy_mode ? ctl_speed(pcs_control) : link.speed;

  always_comb begin
    status_word = 16'h0000;
    status_word[`SLF_STS_AN_DONE] = link.an_done;
    status_word[`SLF_STS_LINK] = link.link_up;
    status_word[`SLF_STS_SPEED_MSB:`SLF_STS_SPEED_LSB] = rep_speed;
    status_word[`SLF_STS_DUPLEX] = link.full_duplex;
  end

  assign addr_wr = ce && req.wr && req.wide && hit(req.addr, `SLF_INDIRECT_ADDRESS_OFS);
  assign data_wr = ce && req.wr && !req.wide && hit(req.addr, `SLF_INDIRECT_DATA_OFS);
  assign data_rd = ce && req.rd && hit(req.addr, `SLF_INDIRECT_DATA_OFS);
  assign ctl_sel = indirect_address == `SLF_PCS_CONTROL_NUM;
  assign sts_sel = indirect_address == `SLF_AUTONEG_STATUS_NUM;

  // ***********************************************
  // Indirect address register.
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_address <= `SLF_INDIRECT_ADDRESS_RST;
    end else if (addr_wr) begin
      indirect_address <= req.wdata;
    end
  end

  // ***********************************************
  // PCS control register, written by the master; the reset bit clears itself.
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcs_control <= `SLF_PCS_CONTROL_RST;
    end else if (data_wr && ctl_sel) begin
      pcs_control <= req.wdata[15:0];
    end else if (ce && pcs_control[`SLF_CTL_RESET]) begin
      pcs_control[`SLF_CTL_RESET] <= 1'b0;
    end
  end

  // ***********************************************
  // Outputs toward the PCS and MAC.
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mac_cfg <= '{speed: `SLF_SPEED_1000, full_duplex: 1'b1, pcs_reset: 1'b0};
    end else if (ce) begin
      mac_cfg.speed <= ctl_speed(pcs_control);
      mac_cfg.full_duplex <= pcs_control[`SLF_CTL_DUPLEX];
      mac_cfg.pcs_reset <= pcs_control[`SLF_CTL_RESET];
    end
  end

  // ***********************************************
  // Auto-negotiation complete event.
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      an_done_q <= 1'b0;
      an_done_evt <= 1'b0;
    end else if (ce) begin
      an_done_q <= link.an_done;
      an_done_evt <= link.an_done && !an_done_q;
    end
  end

  // ***********************************************
  // Read data and acknowledge.
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
    end else if (ce) begin
      ack <= req.wr || req.rd;
      if (req.rd) begin
        if (hit(req.addr, `SLF_INDIRECT_ADDRESS_OFS)) begin
          rdata <= indirect_address;
        end else if (data_rd && ctl_sel) begin
          rdata <= {16'h0000, pcs_control};
        end else if (data_rd && sts_sel) begin
          rdata <= {16'h0000, status_word};
        end else begin
          rdata <= 32'h00000000;
        end
      end
    end
  end

endmodule : slf_link_forward

// >>> sim/slf_link_forward_checker.sv
`timescale 1ns/1ps
module slf_link_forward_checker
  import slf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic phy_mode,
  input wire slf_req_s req,
  input wire logic ack,
  input wire logic [31:0] rdata,
  input wire slf_link_s link,
  input wire slf_mac_cfg_s mac_cfg,
  input wire logic an_done_evt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_at(n); req.wr && req.addr == 16'h7200 && req.wdata == n; endsequence
  sequence s_ctl; s_at(32'h1f0000) ##1 req.wr && req.addr == 16'h7206; endsequence
  sequence s_sts; s_at(32'h1f8002) ##1 req.rd && req.addr == 16'h7206 && !phy_mode; endsequence
  property p_ack; ce && (req.wr || req.rd) |=> ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_idle; !req.wr && !req.rd |=> !ack; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_rst; $rose(rst_n) |-> mac_cfg.speed == 2'h2; endproperty
  a_rst: assert property (p_rst) else $error("reset speed");
  property p_hold; !req.wr [*4] |-> $stable(mac_cfg); endproperty
  a_hold: assert property (p_hold) else $error("cfg moved");
  property p_spd; s_ctl |-> ##2 mac_cfg.speed == {$past(req.wdata[6], 2), $past(req.wdata[13], 2)};
  endproperty
  a_spd: assert property (p_spd) else $error("cfg speed");
  property p_sts; s_sts |=> rdata[3:2] == $past(link.speed); endproperty
  a_sts: assert property (p_sts) else $error("status speed");
  property p_evt; $rose(link.an_done) && ce && $past(ce) |=> an_done_evt; endproperty
  a_evt: assert property (p_evt) else $error("no autoneg event");
  property p_evt1; an_done_evt && ce |=> !an_done_evt; endproperty
  a_evt1: assert property (p_evt1) else $error("long autoneg event");
  property p_frz; !ce |=> $stable(mac_cfg) && $stable(ack) && $stable(rdata); endproperty
  a_frz: assert property (p_frz) else $error("moved while frozen");
endmodule : slf_link_forward_checker
bind slf_link_forward slf_link_forward_checker i_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .phy_mode(phy_mode), .req(req), .ack(ack), .rdata(rdata), .link(link), .mac_cfg(mac_cfg),
  .an_done_evt(an_done_evt));

// >>> sim/slf_host.sv
`timescale 1ns/1ps
module slf_host
  import slf_pkg::*;
(
  input wire logic clk,
  output slf_req_s req,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  logic [31:0] q;
  initial req = '0;
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    #1 req = '{w, !w, a == 16'h7200, a, d};
    @(posedge clk);
    #1 req = '0;
    q = ack ? rdata : '1;
  endtask : acc
  task automatic fwd();
    logic [1:0] s;
    acc(1'h1, 16'h7200, 32'h1f8002);
    acc(1'h0, 16'h7206, 32'h0);
    s = q[3:2];
    acc(1'h1, 16'h7200, 32'h1f0000);
    acc(1'h1, 16'h7206, s == 2'h2 ? 32'h1140 : s == 2'h1 ? 32'h3100 : 32'h1100);
  endtask : fwd
endmodule : slf_host

// >>> sim/slf_link_forward_tb.sv
`timescale 1ns/1ps
module slf_link_forward_tb;
  import slf_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ce = 1'h1;
  logic phy_mode = 1'h0;
  logic ack;
  logic [31:0] rdata;
  slf_link_s link = '0;
  slf_req_s req;
  slf_mac_cfg_s mac_cfg;
  int bad_count = 0;
  int checks_done = 0;
  int s;
  int exp_q[$] = {2};
  always #12.5 clk = ~clk;
  slf_link_forward i_slf_link_forward (.clk(clk), .rst_n(rst_n), .ce(ce), .phy_mode(phy_mode),
    .req(req), .ack(ack), .rdata(rdata), .link(link), .mac_cfg(mac_cfg), .an_done_evt());
  slf_host i_slf_host (.clk(clk), .req(req), .ack(ack), .rdata(rdata));
  task automatic cmp(input logic [1:0] got, input int e);
    checks_done++;
    if (got !== e[1:0]) begin
      bad_count++;
      $display("[ERR] %0t speed %b", $time, got);
    end
  endtask : cmp
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end
  initial begin
    s = $urandom(32'hcc62);
    repeat (6) @(posedge clk);
    #1 rst_n = 1'h1;
    cmp(mac_cfg.speed, 2);
    repeat (8) begin
      s = $urandom_range(2, 0);
      link = '{1'h0, 1'h1, s[1:0], 1'h1};
      repeat (2) @(posedge clk);
      #1 ce = 1'h0;
      @(posedge clk);
      #1 ce = 1'h1;
      link.an_done = 1'h1;
      repeat (4) @(posedge clk);
      cmp(mac_cfg.speed, exp_q[$]);
      i_slf_host.fwd();
      cmp(i_slf_host.q[3:2], s);
      exp_q.push_back(s);
      @(posedge clk);
      #1 cmp(mac_cfg.speed, exp_q[$]);
      cmp({1'h0, mac_cfg.full_duplex}, 1);
    end
    @(posedge clk);
    #1 phy_mode = 1'h1;
    i_slf_host.acc(1'h1, 16'h7200, 32'h1f8002);
    i_slf_host.acc(1'h0, 16'h7206, 32'h0);
    cmp(i_slf_host.q[3:2], exp_q[$]);
    finish_test();
  end
endmodule : slf_link_forward_tb
